//--- hw/ipc_arb_if.sv
`timescale 1ns/1ps
interface ipc_arb_if #(parameter int N = 16, parameter int LW = 4);
  logic [N-1:0]        req;
  logic [N*LW-1:0]     lvl;
  logic                found;
  logic [$clog2(N)-1:0] idx;
  logic [LW-1:0]       best;
  modport ctrl (output req, output lvl, input found, input idx, input best);
  modport arb  (input req, input lvl, output found, output idx, output best);
endinterface

//--- hw/ipc_arbiter.sv
`timescale 1ns/1ps
module ipc_arbiter #(
  parameter int N  = 16,
  parameter int LW = 4
) (
  ipc_arb_if.arb a
);
  // Chain: higher level wins; on a tie the lower index wins (strict >)
  localparam int IW = $clog2(N);
  logic [N:0]           c_found;
  logic [LW-1:0]        c_best [N+1];
  logic [$clog2(N)-1:0] c_idx  [N+1];
  assign c_found[0] = 1'b0;
  assign c_best[0]  = '0;
  assign c_idx[0]   = '0;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_stage
      wire [LW-1:0] lv   = a.lvl[i*LW +: LW];
      wire          take = a.req[i] && (!c_found[i] || lv > c_best[i]); // [R3]
      assign c_found[i+1] = c_found[i] | a.req[i];
      assign c_best[i+1]  = take ? lv : c_best[i];
      assign c_idx[i+1]   = take ? IW'(i) : c_idx[i];
    end
  endgenerate
  assign a.found = c_found[N];
  assign a.best  = c_best[N];
  assign a.idx   = c_idx[N];
endmodule

//--- hw/ipc_ctrl.sv
`timescale 1ns/1ps
// Contract
// (R1) Pending requests are scheduled by priority; higher priority preempts running service.
// (R2) Each source owns a distinct 9-bit vector identifying its service routine.
// (R3) Sixteen levels; ties at one level resolved by fixed index order.
// (R4) Software writes each source's priority level.
// (R5) Software current-priority mask blocks requests not exceeding it.
// (R6) One controller instance per processor core, serving only that core.
// (R7) On accept, present vector and hold its priority until end of service; a mask_wr during service still overwrites cur_pri here.
module ipc_ctrl #(
  parameter int N = ipc_pkg::NUM_SRC,
  parameter int D = ipc_pkg::STK_DEPTH
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     srst,
  // Peripheral requests, level sensitive
  input  wire logic [N-1:0]             irq_in,
  // Priority configuration
  input  wire logic                     lvl_wr,
  input  wire logic [$clog2(N)-1:0]     lvl_sel,
  input  wire logic [ipc_pkg::LVL_W-1:0] lvl_data,
  input  wire logic                     mask_wr,
  input  wire logic [ipc_pkg::LVL_W-1:0] mask_data,
  // Core handshake
  input  wire logic                     core_ack,
  input  wire logic                     core_eoi,
  output logic                          core_irq,
  output logic [ipc_pkg::VEC_W-1:0]     core_vec,
  output logic [ipc_pkg::LVL_W-1:0]     cur_pri,
  output logic                          stk_full
);
  localparam int SW = $clog2(D + 1);
  localparam int IW = $clog2(N);
  localparam int LW = ipc_pkg::LVL_W;

  logic [N*LW-1:0]     lvl;
  logic [LW-1:0]       stk [D];
  logic [SW-1:0]       sp;
  ipc_pkg::ipc_state_t state;
  ipc_pkg::ipc_state_t next_state;
  logic [IW-1:0]       held_idx;

  ipc_arb_if #(.N(N), .LW(LW)) arb_bus ();
  assign arb_bus.req = irq_in;
  assign arb_bus.lvl = lvl;
  ipc_arbiter #(.N(N), .LW(LW)) u_arb (.a(arb_bus));

  // Vector is the source index, so each is unique; width fixed to 9
  wire [ipc_pkg::VEC_W-1:0] win_vec = ipc_pkg::VEC_W'(arb_bus.idx);  // [R2]
  // Level 0 never interrupts since it cannot exceed any ceiling
  wire beats   = arb_bus.found && (arb_bus.best > cur_pri);          // [R1] [R5]
  wire room    = (sp != SW'(D));
  wire offer   = beats && room;
  wire accept  = (state == ipc_pkg::IPC_OFFER) && core_ack;
  wire pop     = core_eoi && (sp != '0) && !accept;
  // Request dropped before ack withdraws the offer
  wire lost    = (state == ipc_pkg::IPC_OFFER) && !core_ack && !offer;

  always_comb begin
    next_state = state;
    unique case (state)
      ipc_pkg::IPC_IDLE:   if (offer) next_state = ipc_pkg::IPC_OFFER;
      ipc_pkg::IPC_OFFER:  if (accept) next_state = ipc_pkg::IPC_ACCEPT;
                           else if (lost) next_state = ipc_pkg::IPC_IDLE;
      ipc_pkg::IPC_ACCEPT: next_state = ipc_pkg::IPC_IDLE;
      default:             next_state = ipc_pkg::IPC_IDLE;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lvl
      always_ff @(posedge mclk) begin
        if (srst) lvl[g*LW +: LW] <= ipc_pkg::LVL_RESET;
        else if (lvl_wr && lvl_sel == IW'(g)) lvl[g*LW +: LW] <= lvl_data;  // [R4]
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (srst) state <= ipc_pkg::IPC_IDLE;
    else      state <= next_state;
  end

  // Offered vector tracks a better winner until the core takes it
  always_ff @(posedge mclk) begin
    if (srst) held_idx <= '0;
    else if (offer && state != ipc_pkg::IPC_ACCEPT && !accept) held_idx <= arb_bus.idx;  // [R1]
  end

  // Stack of preempted priorities; sp counts nested services
  always_ff @(posedge mclk) begin
    if (srst) begin
      sp <= '0;
    end else if (accept) begin
      stk[sp[$clog2(D)-1:0]] <= cur_pri;                              // [R7]
      sp <= sp + SW'(1);
    end else if (pop) begin
      sp <= sp - SW'(1);
    end
  end

  // Current priority: accepted level, restored on end of service,
  // mask write elevates or lowers it for the ceiling protocol
  always_ff @(posedge mclk) begin
    if (srst) cur_pri <= ipc_pkg::MASK_RESET;
    else if (accept) cur_pri <= lvl[held_idx*LW +: LW];               // [R7]
    else if (pop) cur_pri <= stk[sp[$clog2(D)-1:0] - 1'b1];           // [R7]
    else if (mask_wr) cur_pri <= mask_data;                           // [R5]
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      core_irq <= 1'b0;
      core_vec <= ipc_pkg::VEC_NONE;
      stk_full <= 1'b0;
    end else begin
      core_irq <= (next_state == ipc_pkg::IPC_OFFER);                 // [R6]
      if (offer && state != ipc_pkg::IPC_ACCEPT && !accept) core_vec <= win_vec;  // [R2]
      // Tracks the stack depth after this edge, so a pop clears it at once
      stk_full <= (sp == SW'(D) && !pop) || (accept && sp == SW'(D - 1));
    end
  end
endmodule

//--- hw/ipc_pkg.sv
package ipc_pkg;
  localparam int          NUM_SRC   = 16;
  localparam int          VEC_W     = 9;
  localparam int          LVL_W     = 4;
  localparam int          NUM_LVL   = 16;
  localparam int          STK_DEPTH = 16;
  localparam logic [3:0]  LVL_RESET = 4'h0;
  localparam logic [3:0]  MASK_RESET = 4'h0;
  localparam logic [8:0]  VEC_NONE  = 9'h000;
  typedef enum logic [1:0] {
    IPC_IDLE   = 2'b00,
    IPC_OFFER  = 2'b01,
    IPC_ACCEPT = 2'b11
  } ipc_state_t;
endpackage

//--- verif/ipc_core_model.sv
`timescale 1ns/1ps
module ipc_core_model (
  input wire logic       mclk, core_irq,
  input wire logic [3:0] dly,
  output logic           core_ack = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // Acks only while the offer stands, after dly idle cycles
  always @(posedge mclk) begin
    cnt <= (core_irq && !core_ack) ? cnt + 4'h1 : 4'h0;
    core_ack <= core_irq && !core_ack && cnt >= dly;
  end
endmodule

//--- verif/ipc_ctrl_assertions.sv
`timescale 1ns/1ps
module ipc_ctrl_assertions #(parameter int N = 16) (
  input wire logic         mclk, srst, mask_wr, core_ack, core_eoi, core_irq, stk_full,
  input wire logic [N-1:0] irq_in,
  input wire logic [3:0]   mask_data, cur_pri,
  input wire logic [8:0]   core_vec
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence quiet; (irq_in == '0) [*3]; endsequence
  sequence no_cmd; !core_ack && !core_eoi && !mask_wr; endsequence
  sequence acc_eoi; core_ack ##1 no_cmd ##1 (core_eoi && !core_ack); endsequence
  a_ack_drops_irq: assert property (core_ack |=> !core_irq) else $error("offer held after ack");
  a_idle_no_irq: assert property (quiet |=> !core_irq) else $error("offer with no request");
  a_pri_steady: assert property (no_cmd |=> $stable(cur_pri)) else $error("priority moved");
  a_mask_load: assert property (mask_wr && !core_ack && !core_eoi |=> cur_pri == $past(mask_data))
    else $error("mask not loaded");
  a_vec_range: assert property (core_irq |-> core_vec < N) else $error("vector out of range");
  a_full_blocks: assert property ((stk_full && !core_eoi && !core_irq) [*2] |=> !core_irq)
    else $error("offer while stack full");
  a_eoi_restore: assert property (acc_eoi |=> cur_pri == $past(cur_pri, 3))
    else $error("priority not restored");
endmodule
bind ipc_ctrl ipc_ctrl_assertions #(.N(N)) i_chk (.mclk, .srst, .mask_wr, .core_ack, .core_eoi,
  .core_irq, .stk_full, .irq_in, .mask_data, .cur_pri, .core_vec);

//--- verif/prioritized_interrupt_controller_tb.sv
`timescale 1ns/1ps
module prioritized_interrupt_controller_tb;
  logic        mclk = 1'b0, srst = 1'b1, lvl_wr = 1'b0, mask_wr = 1'b0, core_eoi = 1'b0;
  logic [15:0] irq_in = 16'h0000;
  logic [3:0]  lvl_sel = 4'h0, lvl_data = 4'h0, mask_data = 4'h0, dly = 4'h0, cur_pri;
  logic        core_ack, core_irq, stk_full;
  logic [8:0]  core_vec;
  int          err_count = 0, n_checks = 0, cyc = 0;
  ipc_ctrl i_dut (.mclk, .srst, .irq_in, .lvl_wr, .lvl_sel, .lvl_data, .mask_wr, .mask_data,
    .core_ack, .core_eoi, .core_irq, .core_vec, .cur_pri, .stk_full);
  ipc_core_model i_core (.mclk, .core_irq, .dly, .core_ack);
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task setlvl(input logic [3:0] s, input logic [3:0] l);
    @(posedge mclk) {lvl_wr, lvl_sel, lvl_data} <= {1'b1, s, l};
    @(posedge mclk) lvl_wr <= 1'b0;
  endtask
  task mask(input logic [3:0] m);
    @(posedge mclk) {mask_wr, mask_data} <= {1'b1, m};
    @(posedge mclk) mask_wr <= 1'b0;
    #1 chk(cur_pri, m);
  endtask
  task take(input logic [8:0] v, input logic [3:0] p);
    for (int i = 0; i < 20 && core_ack !== 1'b1; i++) @(posedge mclk) #1;
    chk(core_ack, 1);
    chk(core_vec, v);
    @(posedge mclk) #1 chk(cur_pri, p);
    chk(core_irq, 0);
    chk(stk_full, 0);
  endtask
  task quiet;
    repeat (4) @(posedge mclk) #1 chk(core_irq, 0);
  endtask
  // Request dropped together with eoi so it cannot refire
  task eoi(input logic [15:0] d, input logic [3:0] p);
    @(posedge mclk) {irq_in, core_eoi} <= {irq_in & ~d, 1'b1};
    @(posedge mclk) core_eoi <= 1'b0;
    #1 chk(cur_pri, p);
  endtask
  task t_basic;
    setlvl(5, 3);
    irq_in[5] <= 1'b1;
    take(5, 3);
    eoi(16'h0020, 0);
  endtask
  task t_tie;
    @(posedge mclk) dly <= 4'h3;
    setlvl(9, 6);
    setlvl(2, 6);
    irq_in <= 16'h0204;
    take(2, 6);
    quiet;
    eoi(16'h0004, 0);
    take(9, 6);
    eoi(16'h0200, 0);
  endtask
  task t_pre;
    @(posedge mclk) dly <= 4'h0;
    irq_in <= 16'h0020;
    take(5, 3);
    setlvl(7, 9);
    setlvl(1, 2);
    irq_in <= 16'h00a2;
    take(7, 9);
    quiet;
    eoi(16'h0080, 3);
    eoi(16'h0022, 0);
  endtask
  task t_mask;
    mask(4'ha);
    @(posedge mclk) irq_in <= 16'h0080;
    quiet;
    mask(4'h8);
    take(7, 9);
    eoi(16'h0080, 8);
    mask(4'h0);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk) #1 chk(cur_pri, 0);
    t_basic;
    t_tie;
    t_pre;
    t_mask;
    report_and_stop;
  end
endmodule
